// *** hdl/fspc_ctrl.sv ***
// Flash self-programming control: mode, command sequencing, core stall and security lock
// How it works
// - Interrupts during self-programming mode set their flag; serviced only after mode release.
// - Core execution is stalled while a command runs, resumed at completion.
// - No RAM access by the flash operation while a command executes.
// - With batch-erase lock active, erase commands are rejected.
// - New security setting takes effect only at next programming-mode entry.
// - Block erase leaves every byte reading all ones.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.svh"
module fspc_ctrl (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      mode_enter,
    input  wire logic                      mode_exit,
    input  wire logic                      cmd_valid,
    input  wire fspc_pkg::fspc_cmd_t       cmd_code,
    input  wire logic [`FSPC_BLK_W-1:0]    cmd_block,
    input  wire logic [`FSPC_ADDR_W-1:0]   cmd_addr,
    input  wire logic [`FSPC_DATA_W-1:0]   cmd_data,
    input  wire logic                      cmd_lock_req,
    input  wire logic [`FSPC_IRQ_W-1:0]    irq_in,
    input  wire logic [`FSPC_IRQ_W-1:0]    irq_ack,
    input  wire logic                      ram_req_core,
    input  wire logic [`FSPC_ADDR_W+1:0]   rd_addr,
    output logic                           mode_active,
    output logic                           cmd_busy,
    output logic                           cmd_done,
    output logic                           cmd_reject,
    output logic                           core_stall,
    output logic                           ram_en,
    output logic                           lock_active,
    output logic      [`FSPC_DATA_W-1:0]   rd_data,
    output logic      [`FSPC_IRQ_W-1:0]    irq_flag,
    output logic      [`FSPC_IRQ_W-1:0]    irq_service
);
    localparam int NBYTES = 1 << (`FSPC_ADDR_W + `FSPC_BLK_W);
    localparam int BLK_BYTES = 1 << `FSPC_ADDR_W;
    // Erase run length as a plain int so the length check can use it as a delay
    localparam int ERASE_RUN = `FSPC_ERASE_CYC;

    fspc_pkg::fspc_state_t        state_r;
    fspc_pkg::fspc_cmd_t          op_r;
    logic [`FSPC_CNT_W-1:0]       cnt_r;
    logic [`FSPC_BLK_W-1:0]       blk_r;
    logic [`FSPC_ADDR_W-1:0]      addr_r;
    logic [`FSPC_DATA_W-1:0]      data_r;
    logic                         lock_pend_r;
    logic                         mode_r;
    logic                         lock_r;
    logic                         done_r;
    logic                         rej_r;
    logic [`FSPC_DATA_W-1:0]      mem [NBYTES];
    logic                         accept;
    logic                         erase_ok;

    // Flat byte index of a block and offset
    function automatic logic [`FSPC_ADDR_W+`FSPC_BLK_W-1:0] byte_idx(
        input logic [`FSPC_BLK_W-1:0] b, input logic [`FSPC_ADDR_W-1:0] a);
        byte_idx = {b, a};
    endfunction

    assign accept   = cmd_valid && mode_r && state_r == fspc_pkg::FSPC_IDLE;
    assign erase_ok = !(cmd_code == fspc_pkg::FSPC_CMD_ERASE && lock_r);

    // Mode flag; exit is honoured only when no command runs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_r <= 1'b0;
        end else if (mode_enter && !mode_r) begin
            mode_r <= 1'b1;
        end else if (mode_exit && state_r == fspc_pkg::FSPC_IDLE) begin
            mode_r <= 1'b0;
        end
    end

    // Security: the pending setting is promoted only on the next entry
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lock_pend_r <= 1'b0;
            lock_r      <= 1'b0;
        end else begin
            if (accept && cmd_code == fspc_pkg::FSPC_CMD_SECURE && cmd_lock_req) begin
                lock_pend_r <= 1'b1;
            end
            if (mode_enter && !mode_r) begin
                lock_r <= lock_pend_r;
            end
        end
    end

    // Command sequencer: latch, count the cell time, then finish
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= fspc_pkg::FSPC_IDLE;
            op_r    <= fspc_pkg::FSPC_CMD_NONE;
            cnt_r   <= `FSPC_CNT_W'h00;
            blk_r   <= `FSPC_BLK_W'h0;
            addr_r  <= `FSPC_ADDR_W'h00;
            data_r  <= `FSPC_DATA_W'h00;
            done_r  <= 1'b0;
            rej_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            rej_r  <= 1'b0;
            case (state_r)
                fspc_pkg::FSPC_IDLE: begin
                    if (accept && !erase_ok) begin
                        rej_r <= 1'b1;
                    end else if (accept && cmd_code != fspc_pkg::FSPC_CMD_NONE) begin
                        state_r <= fspc_pkg::FSPC_RUN;
                        op_r    <= cmd_code;
                        blk_r   <= cmd_block;
                        addr_r  <= cmd_addr;
                        data_r  <= cmd_data;
                        cnt_r   <= (cmd_code == fspc_pkg::FSPC_CMD_ERASE)
                                   ? `FSPC_CNT_W'(`FSPC_ERASE_CYC) : `FSPC_CNT_W'(`FSPC_WRITE_CYC);
                    end
                end
                fspc_pkg::FSPC_RUN: begin
                    if (cnt_r == `FSPC_CNT_W'h01) begin
                        state_r <= fspc_pkg::FSPC_IDLE;
                        done_r  <= 1'b1;
                    end
                    cnt_r <= cnt_r - `FSPC_CNT_W'h01;
                end
                default: state_r <= fspc_pkg::FSPC_IDLE;
            endcase
        end
    end

    // Flash array; erase blanks the block at its last cycle, write only clears bits
    always_ff @(posedge clk) begin
        if (state_r == fspc_pkg::FSPC_RUN && op_r == fspc_pkg::FSPC_CMD_ERASE
            && cnt_r == `FSPC_CNT_W'h01) begin
            // Whole block at once, so no offset is left holding old data
            for (int j = 0; j < BLK_BYTES; j++) begin
                mem[byte_idx(blk_r, `FSPC_ADDR_W'(j))] <= `FSPC_BLANK_BYTE;
            end
        end else if (state_r == fspc_pkg::FSPC_RUN && op_r == fspc_pkg::FSPC_CMD_WRITE
                     && cnt_r == `FSPC_CNT_W'h01) begin
            // Programming can only pull bits low, so locked parts cannot rewrite data
            mem[byte_idx(blk_r, addr_r)] <= mem[byte_idx(blk_r, addr_r)] & data_r;
        end
    end

    // Read port registered; data output comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= `FSPC_DATA_W'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

    fspc_irq_hold u_irq (
        .clk         (clk),
        .reset_n     (reset_n),
        .mode_active (mode_r),
        .irq_in      (irq_in),
        .irq_ack     (irq_ack),
        .irq_flag    (irq_flag),
        .irq_service (irq_service)
    );

    assign mode_active = mode_r;
    assign cmd_busy    = state_r == fspc_pkg::FSPC_RUN;
    assign core_stall  = state_r == fspc_pkg::FSPC_RUN;
    // RAM port is gated shut during a command; the flash op owns no RAM path
    assign ram_en      = ram_req_core && state_r != fspc_pkg::FSPC_RUN;
    assign lock_active = lock_r;
    assign cmd_done    = done_r;
    assign cmd_reject  = rej_r;

    sequence s_cmd_start;
        accept && erase_ok && cmd_code != fspc_pkg::FSPC_CMD_NONE;
    endsequence
    sequence s_stalled_run;
        core_stall [*4];
    endsequence
    // Write and security runs: eight busy cycles, then done with busy low
    sequence s_short_run;
        cmd_busy [*8] ##1 (cmd_done && !cmd_busy);
    endsequence
    sequence s_erase_run;
        ##ERASE_RUN (cmd_done && !cmd_busy);
    endsequence

    a_stall_on_cmd: assert property (@(posedge clk) disable iff (!reset_n)
        s_cmd_start |=> s_stalled_run)
        else $error("core not stalled while command runs");
    a_stall_release: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_done |-> !core_stall)
        else $error("core still stalled after completion");
    a_short_length: assert property (@(posedge clk) disable iff (!reset_n)
        s_cmd_start ##0 cmd_code != fspc_pkg::FSPC_CMD_ERASE |=> s_short_run)
        else $error("write or security run has wrong length");
    a_erase_length: assert property (@(posedge clk) disable iff (!reset_n)
        s_cmd_start ##0 cmd_code == fspc_pkg::FSPC_CMD_ERASE |=> s_erase_run)
        else $error("erase run has wrong length");
    a_ram_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_busy |-> !ram_en)
        else $error("RAM enabled during command");
    a_erase_locked: assert property (@(posedge clk) disable iff (!reset_n)
        accept && cmd_code == fspc_pkg::FSPC_CMD_ERASE && lock_r |=> cmd_reject && !cmd_busy)
        else $error("erase accepted while locked");
    a_lock_no_erase: assert property (@(posedge clk) disable iff (!reset_n)
        lock_r |-> !(cmd_busy && op_r == fspc_pkg::FSPC_CMD_ERASE))
        else $error("erase running under lock");
    a_lock_deferred: assert property (@(posedge clk) disable iff (!reset_n)
        mode_r && $past(mode_r) |-> $stable(lock_r))
        else $error("security changed inside session");
    a_lock_entry: assert property (@(posedge clk) disable iff (!reset_n)
        mode_enter && !mode_r |=> lock_r == $past(lock_pend_r))
        else $error("security setting not applied at entry");
    a_erase_blank: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == fspc_pkg::FSPC_RUN && op_r == fspc_pkg::FSPC_CMD_ERASE && cnt_r == `FSPC_CNT_W'h01
        |=> mem[byte_idx($past(blk_r), `FSPC_ADDR_W'h00)] == `FSPC_BLANK_BYTE
            && mem[byte_idx($past(blk_r), `FSPC_ADDR_W'hFF)] == `FSPC_BLANK_BYTE)
        else $error("erased byte not blank");
endmodule // fspc_ctrl
`default_nettype wire

// *** hdl/fspc_map.svh ***
// Constants for the flash self-programming controller
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
`define FSPC_ADDR_W      8
`define FSPC_DATA_W      8
`define FSPC_BLANK_BYTE  8'hFF
`define FSPC_ERASE_TIME_NS 100
`define FSPC_WRITE_TIME_NS 40
`define FSPC_CLK_PERIOD_NS 5
`define FSPC_ERASE_CYC   ((`FSPC_ERASE_TIME_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)
`define FSPC_WRITE_CYC   ((`FSPC_WRITE_TIME_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)
`define FSPC_CNT_W       8
`define FSPC_BLK_W       2
`define FSPC_IRQ_W       8
`endif

// *** hdl/fspc_pkg.sv ***
// Types for the flash self-programming controller
`default_nettype none
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_CMD_NONE,
        FSPC_CMD_ERASE,
        FSPC_CMD_WRITE,
        FSPC_CMD_SECURE
    } fspc_cmd_t;
    typedef enum {
        FSPC_IDLE,
        FSPC_RUN
    } fspc_state_t;
endpackage
`default_nettype wire

// *** hdl/fspc_irq_hold.sv ***
// Pending interrupt holder used while self-programming mode is active
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.svh"
module fspc_irq_hold (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      mode_active,
    input  wire logic [`FSPC_IRQ_W-1:0]    irq_in,
    input  wire logic [`FSPC_IRQ_W-1:0]    irq_ack,
    output logic      [`FSPC_IRQ_W-1:0]    irq_flag,
    output logic      [`FSPC_IRQ_W-1:0]    irq_service
);
    logic [`FSPC_IRQ_W-1:0] flag_r;

    // Set wins over acknowledge so a request in the clear cycle survives
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag_r <= `FSPC_IRQ_W'h00;
        end else begin
            flag_r <= (flag_r & ~irq_ack) | irq_in;
        end
    end

    assign irq_flag    = flag_r;
    // Service is withheld for the whole mode, released on exit
    assign irq_service = mode_active ? `FSPC_IRQ_W'h00 : flag_r;

    a_irq_held_mode: assert property (@(posedge clk) disable iff (!reset_n)
        mode_active |-> irq_service == `FSPC_IRQ_W'h00)
        else $error("interrupt serviced during self-programming mode");
    a_irq_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        irq_in != `FSPC_IRQ_W'h00 |=> (irq_flag & $past(irq_in)) == $past(irq_in))
        else $error("interrupt request flag not set");
endmodule // fspc_irq_hold
`default_nettype wire

// *** bench/fspc_fw_model.sv ***
// Firmware model driving the controller's mode and command inputs
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.svh"
module fspc_fw_model (
    input  wire logic                    clk,
    input  wire logic                    cmd_done,
    input  wire logic                    cmd_reject,
    output var  logic                    mode_enter,
    output var  logic                    mode_exit,
    output var  logic                    cmd_valid,
    output var  fspc_pkg::fspc_cmd_t     cmd_code,
    output var  logic [`FSPC_BLK_W-1:0]  cmd_block,
    output var  logic [`FSPC_ADDR_W-1:0] cmd_addr,
    output var  logic [`FSPC_DATA_W-1:0] cmd_data,
    output var  logic                    cmd_lock_req
);
    logic [7:0] interrupt_mask_reg_low;
    logic [7:0] interrupt_mask_reg_high;
    logic       cmd_open;
    int         wd_count;
    // Idle firmware from time zero
    initial begin
        {mode_enter, mode_exit, cmd_valid, cmd_lock_req} = 4'h0;
        cmd_code = fspc_pkg::FSPC_CMD_NONE;
        {cmd_block, cmd_addr, cmd_data} = 18'h0;
        {interrupt_mask_reg_low, interrupt_mask_reg_high} = 16'h0;
        cmd_open = 1'b0;
        wd_count = 0;
    end
    // Mask everything first, then the one-cycle mode switch request
    task automatic enter_mode();
        interrupt_mask_reg_low = 8'hFF;
        interrupt_mask_reg_high = 8'hFF;
        @(posedge clk) #1 mode_enter = 1'b1;
        @(posedge clk) #1 mode_enter = 1'b0;
    endtask
    // Leaving and re-entering is the only way to arm a new security setting
    task automatic leave_mode();
        @(posedge clk) #1 mode_exit = 1'b1;
        @(posedge clk) #1 mode_exit = 1'b0;
    endtask
    // One command; cnt counts edges from the taking edge to the one that raises done or reject
    task automatic issue(input fspc_pkg::fspc_cmd_t c, input logic [1:0] b, input logic [7:0] a,
                         input logic [7:0] d, input logic l, output int cnt);
        wd_count = 0;
        @(posedge clk) #1 cmd_valid = 1'b1;
        cmd_code = c;
        cmd_block = b;
        cmd_addr = a;
        cmd_data = d;
        cmd_lock_req = l;
        @(posedge clk) #1 cmd_valid = 1'b0;
        // A refusal shows at once; otherwise the core sits stalled until done
        cmd_open = !cmd_reject;
        cnt = 0;
        while (!(cmd_done | cmd_reject) && cnt < 40) begin
            @(posedge clk) #1 cnt++;
        end
        cmd_open = 1'b0;
    endtask
endmodule // fspc_fw_model
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`default_nettype none
`include "fspc_map.svh"
module testbench;
    logic clk = 1'b0;
    logic reset_n, mode_enter, mode_exit, cmd_valid, cmd_lock_req, ram_req_core;
    logic mode_active, cmd_busy, cmd_done, cmd_reject, core_stall, ram_en, lock_active;
    fspc_pkg::fspc_cmd_t cmd_code;
    logic [1:0] cmd_block;
    logic [7:0] cmd_addr, cmd_data, irq_in, irq_ack, rd_data, irq_flag, irq_service, d, v;
    logic [9:0] rd_addr;
    logic [31:0] seed = 32'h0000_4718;
    logic [31:0] rnd;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;
    int i;
    always #2.5 clk = ~clk;
    fspc_ctrl dut_u (.clk(clk), .reset_n(reset_n), .mode_enter(mode_enter), .mode_exit(mode_exit),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_block(cmd_block), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_lock_req(cmd_lock_req), .irq_in(irq_in), .irq_ack(irq_ack),
        .ram_req_core(ram_req_core), .rd_addr(rd_addr), .mode_active(mode_active), .cmd_busy(cmd_busy),
        .cmd_done(cmd_done), .cmd_reject(cmd_reject), .core_stall(core_stall), .ram_en(ram_en),
        .lock_active(lock_active), .rd_data(rd_data), .irq_flag(irq_flag), .irq_service(irq_service));
    fspc_fw_model fw_u (.clk(clk), .cmd_done(cmd_done), .cmd_reject(cmd_reject), .mode_enter(mode_enter),
        .mode_exit(mode_exit), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_block(cmd_block),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_lock_req(cmd_lock_req));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic read_chk(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk) #1 rd_addr = a;
        @(posedge clk) #2 check("rd_data", rd_data, e);
    endtask
    // Note the expected event, run the command, then check its length; a hang ends the run
    task automatic cmd(input fspc_pkg::fspc_cmd_t c, input logic [1:0] b, input logic [7:0] a,
                       input logic [7:0] dd, input logic l, input logic [7:0] ev, input int n);
        int cnt;
        exp_q.push_back(ev);
        fw_u.issue(c, b, a, dd, l, cnt);
        check("cmd_cycles", 8'(cnt), 8'(n));
        if (cnt >= 40) wrap_up();
    endtask
    // Random core RAM requests throughout, so gating is seen both ways
    always @(posedge clk) begin
        #1;
        seed = xs(seed);
        ram_req_core = seed[0];
    end
    // Output watcher: stall, RAM gating and command events against the queue
    always @(posedge clk) begin
        #2;
        if (reset_n === 1'b1) begin
            // Expected stall comes from the firmware's own view of an open command
            check("core_stall", {7'h0, core_stall}, {7'h0, fw_u.cmd_open});
            check("cmd_busy", {7'h0, cmd_busy}, {7'h0, fw_u.cmd_open});
            check("ram_en", {7'h0, ram_en}, {7'h0, ram_req_core & ~fw_u.cmd_open});
            if ((cmd_done | cmd_reject) === 1'b1) begin
                check("event", {6'h0, cmd_reject, cmd_done}, exp_q.size() ? exp_q.pop_front() : 8'hEE);
            end
        end
    end
    initial begin
        {reset_n, irq_in, irq_ack, rd_addr, ram_req_core} = 28'h0;
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        check("lock_active", {7'h0, lock_active}, 8'h00);
        fw_u.enter_mode();
        check("mode_active", {7'h0, mode_active}, 8'h01);
        cmd(fspc_pkg::FSPC_CMD_ERASE, 2'h0, 8'h00, 8'h00, 1'b0, 8'h01, `FSPC_ERASE_CYC);
        // Probe across the whole block, last offset included
        for (i = 0; i < 32; i++) read_chk(10'(i * 8 + 7), `FSPC_BLANK_BYTE);
        rnd = xs(seed);
        d = rnd[7:0];
        cmd(fspc_pkg::FSPC_CMD_WRITE, 2'h0, 8'h03, d, 1'b0, 8'h01, `FSPC_WRITE_CYC);
        read_chk(10'h003, d);
        cmd(fspc_pkg::FSPC_CMD_SECURE, 2'h0, 8'h00, 8'h00, 1'b1, 8'h01, `FSPC_WRITE_CYC);
        check("lock_active", {7'h0, lock_active}, 8'h00);
        cmd(fspc_pkg::FSPC_CMD_ERASE, 2'h1, 8'h00, 8'h00, 1'b0, 8'h01, `FSPC_ERASE_CYC);
        read_chk(10'h1FF, `FSPC_BLANK_BYTE);
        // Interrupt inside the mode is held, then released by leaving the mode
        v = d | 8'h01;
        @(posedge clk) #1 irq_in = v;
        @(posedge clk) #1 irq_in = 8'h00;
        #1 check("irq_flag", irq_flag, v);
        check("irq_service", irq_service, 8'h00);
        fw_u.leave_mode();
        check("irq_service", irq_service, v);
        @(posedge clk) #1 irq_ack = v;
        @(posedge clk) #1 irq_ack = 8'h00;
        #1 check("irq_flag", irq_flag, 8'h00);
        fw_u.enter_mode();
        check("lock_active", {7'h0, lock_active}, 8'h01);
        // A refused erase raises its pulse at the taking edge itself, so zero edges
        cmd(fspc_pkg::FSPC_CMD_ERASE, 2'h0, 8'h00, 8'h00, 1'b0, 8'h02, 0);
        read_chk(10'h003, d);
        // Under lock a write cannot raise programmed bits back to blank
        cmd(fspc_pkg::FSPC_CMD_WRITE, 2'h0, 8'h03, 8'hFF, 1'b0, 8'h01, `FSPC_WRITE_CYC);
        read_chk(10'h003, d);
        wrap_up();
    end
    // Guard against a hang outside the bounded waits
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
